// ### rtl/pgahe_pkg.sv
// Purpose: Shared constants and carriers for the pattern generator control
// Assumes: Classic Wishbone slave, 32-bit words, byte addresses
// Notes: All offsets, the CTRL, START and CMD field positions, reset values and counts live here
package pgahe_pkg;
	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int PGAHE_STORE_BITS = 8192; // Nonvolatile store size
	localparam int PGAHE_IW = 14; // Width of lengths and counts
	localparam int PGAHE_PW = 15; // Width of physical store index
	localparam int PGAHE_BW = 22; // Width of burst bit counter
	localparam int PGAHE_EW = 30; // Width of error rate counter
	localparam int PGAHE_BURST_LOG2 = 8; // Burst granule is 256 bits
	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] PGAHE_CTRL = 8'h00;
	localparam logic [7:0] PGAHE_LEN = 8'h04;
	localparam logic [7:0] PGAHE_START = 8'h08;
	localparam logic [7:0] PGAHE_COUNT = 8'h0C;
	localparam logic [7:0] PGAHE_DATA = 8'h10;
	localparam logic [7:0] PGAHE_CMD = 8'h14;
	localparam logic [7:0] PGAHE_STATUS = 8'h18;
	localparam logic [7:0] PGAHE_STAMP = 8'h1C;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int PGAHE_C_TWO = 0; // two_half_use
	localparam int PGAHE_C_PACK = 4; // Packing, 4 bits
	localparam int PGAHE_C_INT = 8; // Changeover by command
	localparam int PGAHE_C_BURST = 9; // burst_mode
	localparam int PGAHE_C_SELB = 10; // second_half selected
	localparam int PGAHE_C_EEN = 11; // error_injection enable
	localparam int PGAHE_C_EEXT = 12; // External error source
	localparam int PGAHE_C_RATE = 16; // Rate exponent, 4 bits
	localparam int PGAHE_S_HALF = 31; // START: second half target
	localparam int PGAHE_K_ONCE = 0; // CMD: single error
	localparam int PGAHE_K_INSB = 1; // CMD: insert_second_half
	localparam int PGAHE_K_CLR = 2; // CMD: clear refused flag
	// ****************************************************************
	// Reset values and legal settings
	// ****************************************************************
	localparam logic [3:0] PGAHE_PACK1 = 4'h1;
	localparam logic [3:0] PGAHE_PACK8 = 4'h8;
	localparam logic [3:0] PGAHE_RATE_MIN = 4'h3;
	localparam logic [3:0] PGAHE_RATE_MAX = 4'h9;
	localparam logic [3:0] PGAHE_RATE_RST = 4'h6;
	localparam logic [13:0] PGAHE_LEN_RST = 14'h0001;
	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} pgahe_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} pgahe_wb_rsp_t;
	typedef struct packed {
		logic two_half;
		logic pack8;
		logic chg_int;
		logic burst;
		logic sel_b;
		logic err_en;
		logic err_ext;
		logic [3:0] rate_exp;
		logic [13:0] len;
		logic [14:0] cur;
		logic [13:0] left;
		logic [13:0] pos;
		logic out_b;
		logic pend;
		logic [21:0] burst_left;
		logic [29:0] err_cnt;
		logic err_once;
		logic bit_o;
		logic ack;
		logic [31:0] rdat;
		logic refused;
		logic [31:0] stamp;
		logic aux_s1;
		logic aux_s2;
		logic aux_s3;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
	} pgahe_state_t;
endpackage

// ### rtl/pgahe_top.sv
// Purpose: User pattern load and readback, half changeover, error addition
// Assumes: Classic Wishbone slave, one clock, pins synchronised inside
// Notes: One bit of pattern leaves per clock on pattern_bit_out
//
// Overview of operation
// [RL1] Partial write places bits from start position
// [RL2] Second-half target refused in whole-pattern use
// [RL3] Byte count always counts data bytes
// [RL4] Partial readback returns count bits from start
// [RL5] Last change time stamp is read only
// [RL6] Packing accepts one or eight; resets one
// [RL7] One-bit packing: bit in LSB, rest zero
// [RL8] Eight-bit packing: first bit is MSB
// [RL9] Changeover source external or command; resets external
// [RL10] Level mode: auxiliary level picks the half
// [RL11] Command half select, first half after reset
// [RL12] Auxiliary rising edge starts one burst
// [RL13] Insert command starts burst in command mode
// [RL14] Burst length is lcm of length, 256
// [RL15] Single error adds one, stops fixed rate
// [RL16] Error addition enable, off after reset
// [RL17] External pulse adds one error when enabled
// [RL18] Fixed source adds errors at programmed rate
// [RL19] Rate only decades one per thousand to billion
// [RL20] Whole use repeats store; halves follow changeover
// [RL21] Nonvolatile store holds 8192 bits
// [RL22] Each error inverts exactly one output bit
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module pgahe_top
#(
	parameter int STORE_BITS = 8192 // Store size in bits
)
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Register bus
	input wire pgahe_pkg::pgahe_wb_req_t wb_req_in,
	output pgahe_pkg::pgahe_wb_rsp_t wb_rsp_out,
	// Pins and time base
	input wire logic aux_in,
	input wire logic ext_err_in,
	input wire logic [31:0] time_stamp_in,
	// Generated stream
	output logic pattern_bit_out,
	output logic half_b_out
);
	import pgahe_pkg::*;

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (STORE_BITS > PGAHE_STORE_BITS || STORE_BITS < 16)
	begin : g_bad_size
		$error("STORE_BITS out of range");
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Byte-lane merge for partial-width writes
	function automatic logic [31:0] lane_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[8*i +: 8] = n[8*i +: 8];
		end
		return r;
	endfunction

	// Bits between fixed-rate errors for a decade exponent
	function automatic logic [29:0] decade(input logic [3:0] e);
		logic [29:0] r;
		unique case (e)
			4'h3: r = 30'd1000;
			4'h4: r = 30'd10000;
			4'h5: r = 30'd100000;
			4'h6: r = 30'd1000000;
			4'h7: r = 30'd10000000;
			4'h8: r = 30'd100000000;
			default: r = 30'd1000000000;
		endcase
		return r;
	endfunction

	// Least multiple of the length that 256 divides
	function automatic logic [21:0] burst_bits(input logic [13:0] len);
		logic [3:0] tz;
		tz = 4'h0;
		for (int i = 0; i < PGAHE_BURST_LOG2; i++)
		begin
			if (!len[i] && tz == 4'(i))
				tz = tz + 4'h1;
		end
		return {8'h00, len} << (4'h8 - tz);
	endfunction

	// ****************************************************************
	// Storage and state
	// ****************************************************************
	logic mem [STORE_BITS]; // Pattern store, not reset
	pgahe_state_t s_r; // All control state
	pgahe_state_t s_nxt; // Its next value
	logic req; // New bus request this cycle
	logic [31:0] ctrl_v; // CTRL as read
	logic [31:0] rd_v; // Read value of addressed register
	logic [31:0] wm; // Write data merged into old value
	logic [7:0] rbyte; // Readback byte at cursor
	logic [7:0] mem_we; // Per-bit store write enables
	logic [7:0] mem_wb; // Per-bit store write data
	logic [14:0] phys; // Store index being played
	logic raw_bit; // Stored bit before error
	logic wrap; // Last bit of the pattern or half
	logic inj; // Invert the next output bit
	logic aux_rise; // Auxiliary input rising edge
	logic ext_rise; // External error pulse edge
	logic [15:0] bytes_left; // Bytes still due in transfer
	logic [3:0] npk; // Packing field being written
	logic [3:0] nrt; // Rate field being written

	assign req = wb_req_in.cyc && wb_req_in.stb && !s_r.ack;
	assign aux_rise = s_r.aux_s2 && !s_r.aux_s3;
	assign ext_rise = s_r.ext_s2 && !s_r.ext_s3;

	// ****************************************************************
	// Register read view
	// ****************************************************************
	// Byte count follows packing, so software always sees data bytes
	always_comb
	begin
		ctrl_v = '0;
		ctrl_v[PGAHE_C_TWO] = s_r.two_half;
		ctrl_v[PGAHE_C_PACK +: 4] = s_r.pack8 ? PGAHE_PACK8 : PGAHE_PACK1;
		ctrl_v[PGAHE_C_INT] = s_r.chg_int;
		ctrl_v[PGAHE_C_BURST] = s_r.burst;
		ctrl_v[PGAHE_C_SELB] = s_r.sel_b;
		ctrl_v[PGAHE_C_EEN] = s_r.err_en;
		ctrl_v[PGAHE_C_EEXT] = s_r.err_ext;
		ctrl_v[PGAHE_C_RATE +: 4] = s_r.rate_exp;
		bytes_left = s_r.pack8 ? 16'((s_r.left + 14'd7) >> 3)
			: {2'b00, s_r.left}; // RL3
		unique case (wb_req_in.adr)
			PGAHE_CTRL: rd_v = ctrl_v;
			PGAHE_LEN: rd_v = {18'h0, s_r.len};
			PGAHE_START: rd_v = {17'h0, s_r.cur};
			PGAHE_COUNT: rd_v = {18'h0, s_r.left};
			PGAHE_DATA: rd_v = {24'h0, rbyte};
			PGAHE_STATUS: rd_v = {bytes_left, 12'h0, s_r.pend,
				(s_r.burst_left != '0), s_r.out_b, s_r.refused};
			PGAHE_STAMP: rd_v = s_r.stamp; // RL5
			default: rd_v = 32'h0;
		endcase
		wm = lane_merge(rd_v, wb_req_in.dat, wb_req_in.sel);
	end

	// ****************************************************************
	// Store access at the cursor
	// ****************************************************************
	// Readback byte; unused trailing bits read zero
	always_comb
	begin
		rbyte = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			if ((s_r.pack8 || i == 0) && 14'(i) < s_r.left
				&& int'(s_r.cur) + i < STORE_BITS)
			begin
				if (s_r.pack8)
					rbyte[7 - i] = mem[int'(s_r.cur) + i]; // RL4 RL8
				else
					rbyte[0] = mem[int'(s_r.cur)]; // RL4 RL7
			end
		end
		phys = {1'b0, s_r.pos} + (s_r.out_b ? {1'b0, s_r.len} : 15'h0);
		raw_bit = (int'(phys) < STORE_BITS) ? mem[int'(phys)] : 1'b0;
		wrap = (s_r.len <= 14'h0001) || (s_r.pos >= s_r.len - 14'h0001);
	end

	// Store writes, one bit lane per stored bit
	always_ff @(posedge clock_in)
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (mem_we[i] && int'(s_r.cur) + i < STORE_BITS)
				mem[int'(s_r.cur) + i] <= mem_wb[i]; // RL1 RL21
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		s_nxt = s_r;
		mem_we = 8'h00;
		mem_wb = 8'h00;
		npk = wm[PGAHE_C_PACK +: 4];
		nrt = wm[PGAHE_C_RATE +: 4];
		// Pin synchronisers, edges taken from the second stage on
		s_nxt.aux_s1 = aux_in;
		s_nxt.aux_s2 = s_r.aux_s1;
		s_nxt.aux_s3 = s_r.aux_s2;
		s_nxt.ext_s1 = ext_err_in;
		s_nxt.ext_s2 = s_r.ext_s1;
		s_nxt.ext_s3 = s_r.ext_s2;
		// Answer every request one cycle later, unmapped reads zero
		s_nxt.ack = req;
		if (req && !wb_req_in.we)
			s_nxt.rdat = rd_v;
		// Burst trigger from the pin or from the command
		if (s_r.burst && !s_r.chg_int && aux_rise)
			s_nxt.pend = 1'b1; // RL12
		// Stream position and half choice
		if (s_r.out_b && s_r.burst_left != '0)
			s_nxt.burst_left = s_r.burst_left - 22'h1;
		s_nxt.pos = wrap ? 14'h0 : s_r.pos + 14'h1;
		if (wrap)
		begin
			if (!s_r.two_half)
				s_nxt.out_b = 1'b0; // RL20
			else if (!s_r.burst)
				s_nxt.out_b = s_r.chg_int ? s_r.sel_b // RL11
					: s_r.aux_s2; // RL9 RL10
			else if (s_nxt.burst_left != '0)
				s_nxt.out_b = 1'b1;
			else if (s_r.pend)
			begin
				// Burst of whole halves; ends on a half boundary
				s_nxt.out_b = 1'b1;
				// A pin edge or an insert command in this very cycle stays pending
				s_nxt.pend = aux_rise && !s_r.chg_int; // RL12
				s_nxt.burst_left = burst_bits(s_r.len); // RL14
			end
			else
				s_nxt.out_b = 1'b0;
		end
		// Error sources; a single error is consumed on the next bit
		if (s_r.err_en && !s_r.err_ext)
		begin
			if (s_r.err_cnt >= decade(s_r.rate_exp) - 30'h1)
				s_nxt.err_cnt = 30'h0; // RL18
			else
				s_nxt.err_cnt = s_r.err_cnt + 30'h1;
		end
		s_nxt.err_once = 1'b0;
		s_nxt.bit_o = raw_bit ^ inj; // RL22
		// Register writes
		if (req && wb_req_in.we)
		begin
			unique case (wb_req_in.adr)
				PGAHE_CTRL:
				begin
					s_nxt.two_half = wm[PGAHE_C_TWO];
					s_nxt.chg_int = wm[PGAHE_C_INT]; // RL9
					s_nxt.burst = wm[PGAHE_C_BURST];
					s_nxt.sel_b = wm[PGAHE_C_SELB]; // RL11
					s_nxt.err_en = wm[PGAHE_C_EEN]; // RL16
					s_nxt.err_ext = wm[PGAHE_C_EEXT];
					// Restart the count so a smaller decade never overruns
					s_nxt.err_cnt = 30'h0; // RL18
					// Illegal packing or rate keeps the old setting
					if (npk == PGAHE_PACK1 || npk == PGAHE_PACK8)
						s_nxt.pack8 = (npk == PGAHE_PACK8); // RL6
					else
						s_nxt.refused = 1'b1; // RL6
					if (nrt >= PGAHE_RATE_MIN && nrt <= PGAHE_RATE_MAX)
						s_nxt.rate_exp = nrt; // RL19
					else
						s_nxt.refused = 1'b1; // RL19
				end
				PGAHE_LEN:
				begin
					s_nxt.len = wm[13:0];
					s_nxt.pos = 14'h0;
					s_nxt.stamp = time_stamp_in; // RL5
				end
				PGAHE_START:
				begin
					// Second half exists only in two-half use
					if (wm[PGAHE_S_HALF] && !s_r.two_half)
						s_nxt.refused = 1'b1; // RL2
					else
						s_nxt.cur = {1'b0, wm[13:0]} + (wm[PGAHE_S_HALF]
							? {1'b0, s_r.len} : 15'h0); // RL1 RL2
				end
				PGAHE_COUNT: s_nxt.left = wm[13:0];
				PGAHE_DATA:
				begin
					if (wb_req_in.sel[0] && s_r.left != '0)
					begin
						if (!s_r.pack8 && wb_req_in.dat[7:1] != 7'h0)
							s_nxt.refused = 1'b1; // RL7
						else
						begin
							for (int i = 0; i < 8; i++)
							begin
								mem_we[i] = (s_r.pack8 || i == 0)
									&& 14'(i) < s_r.left;
								mem_wb[i] = s_r.pack8
									? wb_req_in.dat[7 - i] // RL8
									: wb_req_in.dat[0]; // RL7
							end
							s_nxt.stamp = time_stamp_in; // RL5
						end
					end
				end
				PGAHE_CMD:
				begin
					if (wb_req_in.sel[0] && wb_req_in.dat[PGAHE_K_ONCE])
					begin
						s_nxt.err_once = 1'b1; // RL15
						s_nxt.err_en = 1'b0; // RL15
					end
					if (wb_req_in.sel[0] && wb_req_in.dat[PGAHE_K_INSB]
						&& s_r.chg_int && s_r.burst)
						s_nxt.pend = 1'b1; // RL13
					if (wb_req_in.sel[0] && wb_req_in.dat[PGAHE_K_CLR])
						s_nxt.refused = 1'b0;
				end
				default: s_nxt.refused = s_r.refused;
			endcase
		end
		// Cursor advance on any data access that moved bits
		if (req && wb_req_in.adr == PGAHE_DATA && wb_req_in.sel[0]
			&& s_r.left != '0 && (mem_we[0] || !wb_req_in.we))
		begin
			if (s_r.pack8 && s_r.left >= 14'h0008)
			begin
				s_nxt.cur = s_r.cur + 15'h8;
				s_nxt.left = s_r.left - 14'h8;
			end
			else if (s_r.pack8)
			begin
				s_nxt.cur = s_r.cur + {1'b0, s_r.left};
				s_nxt.left = 14'h0;
			end
			else
			begin
				s_nxt.cur = s_r.cur + 15'h1;
				s_nxt.left = s_r.left - 14'h1;
			end
		end
		// A refusal raised now wins over a clear in the same cycle
		if (s_nxt.refused != s_r.refused && s_r.refused == 1'b0)
			s_nxt.refused = 1'b1;
	end

	// Error decision feeds the output flop only
	assign inj = s_r.err_once
		|| (s_r.err_en && s_r.err_ext && ext_rise) // RL17
		|| (s_r.err_en && !s_r.err_ext
		&& s_r.err_cnt >= decade(s_r.rate_exp) - 30'h1); // RL18

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			s_r <= '0;
			s_r.rate_exp <= PGAHE_RATE_RST;
			s_r.len <= PGAHE_LEN_RST;
		end
		else
			s_r <= s_nxt;
	end

	assign wb_rsp_out = '{ack: s_r.ack, dat: s_r.rdat};
	assign pattern_bit_out = s_r.bit_o;
	assign half_b_out = s_r.out_b;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence req_wr(logic [7:0] a);
		req && wb_req_in.we && wb_req_in.adr == a && wb_req_in.sel[0];
	endsequence
	sequence once_cmd;
		req_wr(PGAHE_CMD) ##0 wb_req_in.dat[PGAHE_K_ONCE];
	endsequence

	a_ack_single_pulse: assert property (@(posedge clock_in)
		disable iff (!rst_b_in) s_r.ack |=> !s_r.ack)
		else $error("ack held longer than one cycle");
	a_once_stops_rate: assert property (@(posedge clock_in) // RL15
		disable iff (!rst_b_in) once_cmd |=> !s_r.err_en ##1
		(pattern_bit_out != $past(raw_bit)))
		else $error("single error missing or rate left on");
	// Split in two so an unloaded store bit cannot trip either check while no error is added
	a_bit_invert_once: assert property (@(posedge clock_in) // RL22
		disable iff (!rst_b_in)
		(pattern_bit_out != $past(raw_bit)) |-> $past(inj))
		else $error("output bit changed with no error added");
	a_error_inverts: assert property (@(posedge clock_in) // RL22
		disable iff (!rst_b_in)
		$past(inj) |-> pattern_bit_out != $past(raw_bit))
		else $error("error decided but output bit not inverted");
	a_burst_length: assert property (@(posedge clock_in) // RL14
		disable iff (!rst_b_in) (wrap && s_r.two_half && s_r.burst
		&& s_r.pend && s_r.burst_left <= 22'h1)
		|=> s_r.burst_left == burst_bits($past(s_r.len)))
		else $error("burst length is not the 256 multiple");
	a_level_follows: assert property (@(posedge clock_in) // RL10
		disable iff (!rst_b_in) (wrap && s_r.two_half && !s_r.burst
		&& !s_r.chg_int) |=> s_r.out_b == $past(s_r.aux_s2))
		else $error("half does not follow auxiliary level");
	a_select_half: assert property (@(posedge clock_in) // RL11
		disable iff (!rst_b_in) (wrap && s_r.two_half && !s_r.burst
		&& s_r.chg_int) |=> s_r.out_b == $past(s_r.sel_b))
		else $error("half does not follow select setting");
	a_ext_error: assert property (@(posedge clock_in) // RL17
		disable iff (!rst_b_in) (s_r.err_en && s_r.err_ext && ext_rise)
		|=> pattern_bit_out != $past(raw_bit))
		else $error("external pulse added no error");
	a_rate_bound: assert property (@(posedge clock_in) // RL18
		disable iff (!rst_b_in) (s_r.err_en && !s_r.err_ext)
		|-> s_r.err_cnt < decade(s_r.rate_exp))
		else $error("fixed rate counter past its decade");
	a_rate_legal: assert property (@(posedge clock_in) // RL19
		disable iff (!rst_b_in) s_r.rate_exp >= PGAHE_RATE_MIN
		&& s_r.rate_exp <= PGAHE_RATE_MAX)
		else $error("rate outside decade range");
	a_half_refused: assert property (@(posedge clock_in) // RL2
		disable iff (!rst_b_in) (req_wr(PGAHE_START) ##0
		wb_req_in.dat[PGAHE_S_HALF] && wb_req_in.sel[3] && !s_r.two_half)
		|=> s_r.refused && $stable(s_r.cur))
		else $error("second half accepted in whole use");
	a_write_places: assert property (@(posedge clock_in) // RL1
		disable iff (!rst_b_in) (mem_we[0] && !s_r.pack8
		&& int'(s_r.cur) < STORE_BITS)
		|=> mem[int'($past(s_r.cur))] == $past(wb_req_in.dat[0])
		&& s_r.stamp == $past(time_stamp_in))
		else $error("bit not stored at cursor or stamp stale");
endmodule // pgahe_top

// ### test/pgahe_pins.sv
// Purpose: Far-side pins model, auxiliary level and error pulses
// Assumes: Driven from the bench clock, one request per call
// Notes: Pulses are stretched so the 2-flop sync cannot miss them
`timescale 1ns/1ns
module pgahe_pins
(
	// Clock
	input wire logic clock_in,
	// Requests from the bench
	input wire logic lvl_in,
	input wire logic kick_in,
	// Pins toward the block
	output logic aux_out,
	output logic err_out
);
	int n_r = 0; // Pulse cycles left
	initial aux_out = 1'b0;
	initial err_out = 1'b0;
	// Pins move only just after a clock edge
	always @(posedge clock_in)
	begin
		aux_out <= lvl_in;
		if (kick_in)
			n_r <= 4;
		else if (n_r > 0)
			n_r <= n_r - 1;
		err_out <= (n_r > 0);
	end
endmodule // pgahe_pins

// ### test/pgahe_top_tb.sv
// Purpose: Self-checking bench for the pattern generator control
// Assumes: Ack one cycle after take, reads noted in a queue
// Notes: Error tests play a one-bit store of 1, so errors show as 0
`timescale 1ns/1ns
module pgahe_top_tb;
	import pgahe_pkg::*;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic clock_in = 1'b0, rst_b_in = 1'b0;
	pgahe_wb_req_t req = '0;
	pgahe_wb_rsp_t rsp;
	logic aux, ext, bit_o, half_b, lvl = 1'b0, kick = 1'b0;
	logic [31:0] ts = 32'h0, seed = 32'h00016C34, q[$];
	logic [15:0] mem;
	logic [7:0] e0, e1;
	int n_fail = 0, compares = 0;
	always #50 clock_in = ~clock_in;
	pgahe_top u_pgahe_top (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.wb_req_in(req), .wb_rsp_out(rsp), .aux_in(aux),
		.ext_err_in(ext), .time_stamp_in(ts),
		.pattern_bit_out(bit_o), .half_b_out(half_b));
	pgahe_pins u_pgahe_pins (.clock_in(clock_in), .lvl_in(lvl),
		.kick_in(kick), .aux_out(aux), .err_out(ext));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		int i;
		@(posedge clock_in);
		req <= '{1'b1, 1'b1, w, a, 4'hF, d};
		if (!w)
			q.push_back(e);
		i = 0;
		do
		begin
			@(posedge clock_in);
			i++;
		end
		while (rsp.ack !== 1'b1 && i < 50);
		if (i >= 50)
			chk(32'h0, 32'h1);
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, e);
	endtask
	// Counts cycles where a stream output equals v
	task automatic cnt(input logic h, input logic v, input int n,
		input int e);
		int c;
		c = 0;
		repeat (n)
		begin
			@(posedge clock_in);
			#1;
			if ((h ? half_b : bit_o) === v)
				c++;
		end
		chk(c, e);
	endtask
	// Read results are compared in the cycle that carries ack
	always @(posedge clock_in)
		if (rsp.ack === 1'b1 && req.cyc && !req.we && q.size() > 0)
			chk(rsp.dat, q.pop_front());
	task automatic give_verdict();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog well past the expected run of about 8700 cycles
	initial
	begin
		#(60000 * 100);
		n_fail++;
		give_verdict();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (8) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rd(PGAHE_CTRL, 32'h00060010);
		rd(PGAHE_LEN, 32'h00000001);
		rd(PGAHE_STATUS, 32'h0);
		rd(PGAHE_STAMP, 32'h0);
		rd(8'h20, 32'h0);
		$display("test reset values done");
		// Packing other than 1 or 8 is refused
		wr(PGAHE_CTRL, 32'h00060020);
		rd(PGAHE_CTRL, 32'h00060010);
		rd(PGAHE_STATUS, 32'h00000001);
		wr(PGAHE_CMD, 32'h4);
		for (int r = 2; r <= 10; r++)
		begin
			wr(PGAHE_CTRL, {12'h0, r[3:0], 16'h0010});
			if (r >= 3 && r <= 9)
				rd(PGAHE_CTRL, {12'h0, r[3:0], 16'h0010});
			else
				rd(PGAHE_CTRL, {12'h0, ((r < 3) ? PGAHE_RATE_RST
					: PGAHE_RATE_MAX), 16'h0010});
		end
		wr(PGAHE_CMD, 32'h4);
		wr(PGAHE_CTRL, 32'h00060010);
		$display("test settings done");
		// Full load, one bit per byte, random contents
		mem = 16'(xs());
		mem[0] = 1'b1;
		mem[1] = 1'b0;
		wr(PGAHE_LEN, 32'h10);
		wr(PGAHE_START, 32'h0);
		wr(PGAHE_COUNT, 32'h10);
		wr(PGAHE_DATA, 32'h2);
		rd(PGAHE_STATUS, 32'h00100001);
		wr(PGAHE_CMD, 32'h4);
		for (int i = 0; i < 16; i++)
			wr(PGAHE_DATA, {31'h0, mem[i]});
		wr(PGAHE_START, 32'h80000000);
		rd(PGAHE_STATUS, 32'h00000001);
		wr(PGAHE_CMD, 32'h4);
		// Partial write of nine bits at 3, eight bits per byte
		ts <= xs();
		wr(PGAHE_CTRL, 32'h00060080);
		wr(PGAHE_START, 32'h3);
		wr(PGAHE_COUNT, 32'h9);
		rd(PGAHE_STATUS, 32'h00020000);
		wr(PGAHE_DATA, 32'h9B);
		wr(PGAHE_DATA, 32'h80);
		rd(PGAHE_STAMP, ts);
		for (int i = 0; i < 9; i++)
			mem[3 + i] = 9'h137 >> (8 - i);
		for (int i = 0; i < 8; i++)
		begin
			e0[7 - i] = mem[i];
			e1[7 - i] = mem[8 + i];
		end
		wr(PGAHE_START, 32'h0);
		wr(PGAHE_COUNT, 32'h10);
		rd(PGAHE_DATA, {24'h0, e0});
		rd(PGAHE_DATA, {24'h0, e1});
		wr(PGAHE_CTRL, 32'h00060010);
		wr(PGAHE_START, 32'h3);
		wr(PGAHE_COUNT, 32'h9);
		for (int i = 0; i < 9; i++)
			rd(PGAHE_DATA, {31'h0, mem[3 + i]});
		$display("test load and readback done");
		// Whole use repeats the store
		repeat (40) @(posedge clock_in);
		// A length write restarts play at bit 0
		wr(PGAHE_LEN, 32'h10);
		for (int i = 0; i < 48; i++)
		begin
			@(posedge clock_in);
			#1;
			chk(bit_o, mem[(i + 1) % 16]);
		end
		$display("test repeat done");
		// Two halves of one bit each: first 1, second 0
		wr(PGAHE_LEN, 32'h1);
		wr(PGAHE_CTRL, 32'h00060011);
		wr(PGAHE_START, 32'h80000000);
		rd(PGAHE_START, 32'h00000001);
		lvl <= 1'b1;
		cnt(1'b1, 1'b1, 20, 17);
		chk(bit_o, 32'h0);
		lvl <= 1'b0;
		cnt(1'b1, 1'b0, 20, 17);
		wr(PGAHE_CTRL, 32'h00060511);
		lvl <= 1'b0;
		cnt(1'b1, 1'b1, 20, 20);
		wr(PGAHE_CTRL, 32'h00060111);
		lvl <= 1'b1;
		cnt(1'b1, 1'b0, 20, 20);
		lvl <= 1'b0;
		$display("test level changeover done");
		// Bursts: lcm of length and 256
		wr(PGAHE_CTRL, 32'h00060311);
		// Count from the command's own edge so the first burst bit is seen
		fork
			wr(PGAHE_CMD, 32'h2);
			cnt(1'b1, 1'b1, 600, 256);
		join
		wr(PGAHE_LEN, 32'h3);
		wr(PGAHE_CTRL, 32'h00060211);
		lvl <= 1'b1;
		cnt(1'b1, 1'b1, 1500, 768);
		lvl <= 1'b0;
		$display("test bursts done");
		// Errors on a constant stream of ones
		wr(PGAHE_LEN, 32'h1);
		wr(PGAHE_CTRL, 32'h00061010);
		kick <= 1'b1;
		@(posedge clock_in);
		kick <= 1'b0;
		cnt(1'b0, 1'b0, 60, 0);
		wr(PGAHE_CTRL, 32'h00061810);
		kick <= 1'b1;
		@(posedge clock_in);
		kick <= 1'b0;
		cnt(1'b0, 1'b0, 60, 1);
		wr(PGAHE_CTRL, 32'h00030810);
		repeat (500) @(posedge clock_in);
		cnt(1'b0, 1'b0, 3000, 3);
		// The single error shows before the write returns, so count alongside
		fork
			wr(PGAHE_CMD, 32'h1);
			cnt(1'b0, 1'b0, 2500, 1);
		join
		rd(PGAHE_CTRL, 32'h00030010);
		$display("test errors done");
		give_verdict();
	end
endmodule // pgahe_top_tb
